/* File: hdl/dat_core.sv */
// address translation diagnostic page: check, hold, convert and return
//
// Operation
// - The host sends the address in a parameter page and a clean page earns good status.
// - Conversion waits for a receive request and its result is returned as that request's data.
// - Format codes 0, 3, 4 and 5 mean short block, long block, bytes from index, physical sector.
// - Invalid or identical formats end in check condition, illegal request, bad parameter field.
// - Short block takes its address from bytes 6 to 9 and bytes 10 to 13 must be zero.
// - Long block takes bytes 6 to 13 as one 64-bit block address.
// - Physical addresses put cylinder in bytes 6-8, head in 9 and sector or offset in 10-13.
// - Source format sits in byte 4, target format in byte 5, the address in bytes 6 to 13.
`timescale 1ns/1ns
`default_nettype none
module dat_core
	import dat_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// parameter page bytes from the send command
	input wire logic par_valid,
	input wire logic [7:0] par_data,
	input wire logic par_last,
	// receive command request
	input wire logic rcv_req,
	// command status answer
	output logic sts_valid,
	output logic sts_check,
	output logic [3:0] sts_key,
	output logic [7:0] sts_asc,
	// geometry lookup
	output logic geo_req,
	output logic geo_to_phys,
	output logic [2:0] geo_fmt,
	output logic [63:0] geo_lba,
	output logic [23:0] geo_cyl,
	output logic [7:0] geo_head,
	output logic [31:0] geo_sec,
	input wire logic geo_ack,
	input wire logic [63:0] geo_lba_in,
	input wire logic [23:0] geo_cyl_in,
	input wire logic [7:0] geo_head_in,
	input wire logic [31:0] geo_sec_in,
	// answer page bytes for the receive command
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_last,
	input wire logic rsp_ready
);
	// =========================================================
	// format decoding
	// =========================================================
	function automatic logic fmt_block(input logic [2:0] f);
		return (f == FMT_SHORT) || (f == FMT_LONG);
	endfunction : fmt_block

	function automatic logic fmt_phys(input logic [2:0] f);
		return (f == FMT_BFI) || (f == FMT_PSEC);
	endfunction : fmt_phys

	dat_state_e st_q, st_d;
	logic [7:0] pg_q [PAGE_BYTES];
	logic [7:0] pg_d [PAGE_BYTES];
	logic [7:0] res_q [PAGE_BYTES];
	logic [7:0] res_d [PAGE_BYTES];
	logic [3:0] idx_q, idx_d;
	logic [3:0] ridx_q, ridx_d;
	logic have_q, have_d;
	logic sts_valid_q, sts_valid_d, sts_check_q, sts_check_d;
	logic [2:0] sup_w, tgt_w;
	logic tail_zero_w, good_w, take_w;

	// fields come from the page as it will stand after this byte
	assign take_w = par_valid && (st_q == ST_IDLE);
	assign sup_w = pg_d[IDX_SUP][2:0];
	assign tgt_w = pg_d[IDX_TGT][2:0];
	assign tail_zero_w = {pg_d[10], pg_d[11], pg_d[12], pg_d[13]} == 32'h0;
	// identical or unknown codes never satisfy either pairing, so both fall to check
	assign good_w = (idx_q == IDX_LAST)
		&& ((fmt_block(sup_w) && fmt_phys(tgt_w))
		|| (fmt_phys(sup_w) && (tgt_w == FMT_LONG)))
		&& ((sup_w != FMT_SHORT) || tail_zero_w);

	// =========================================================
	// lookup outputs straight from the stored page
	// =========================================================
	assign geo_req = (st_q == ST_LOOK);
	assign geo_fmt = pg_q[IDX_SUP][2:0];
	assign geo_to_phys = fmt_block(pg_q[IDX_SUP][2:0]);
	// short block keeps the upper half of the address at zero
	assign geo_lba = (pg_q[IDX_SUP][2:0] == FMT_SHORT) ?
		{32'h0, pg_q[6], pg_q[7], pg_q[8], pg_q[9]} :
		{pg_q[6], pg_q[7], pg_q[8], pg_q[9], pg_q[10], pg_q[11], pg_q[12], pg_q[13]};
	assign geo_cyl = {pg_q[6], pg_q[7], pg_q[8]};
	assign geo_head = pg_q[9];
	assign geo_sec = {pg_q[10], pg_q[11], pg_q[12], pg_q[13]};

	// answer stream and status
	assign rsp_valid = (st_q == ST_SEND);
	assign rsp_data = res_q[ridx_q];
	assign rsp_last = rsp_valid && (ridx_q == IDX_LAST);
	assign sts_valid = sts_valid_q;
	assign sts_check = sts_check_q;
	assign sts_key = sts_check_q ? KEY_ILLEGAL : KEY_NONE;
	assign sts_asc = sts_check_q ? ASC_BAD_PARAM : ASC_NONE;

	// =========================================================
	// next state: page capture, check, lookup, answer
	// =========================================================
	always_comb begin
		st_d = st_q;
		pg_d = pg_q;
		res_d = res_q;
		idx_d = idx_q;
		ridx_d = ridx_q;
		have_d = have_q;
		sts_valid_d = 1'b0;
		sts_check_d = 1'b0;
		if (take_w && (idx_q != IDX_FULL)) begin
			pg_d[idx_q] = par_data;
		end
		unique case (st_q)
			ST_IDLE: begin
				if (take_w) begin
					idx_d = (idx_q == IDX_FULL) ? idx_q : idx_q + 4'h1;
					if (par_last) begin
						idx_d = 4'h0;
						have_d = good_w;
						sts_valid_d = 1'b1;
						sts_check_d = !good_w;
					end
				end else if (rcv_req) begin
					// a receive with nothing pending answers check at once
					if (have_q) begin
						st_d = ST_LOOK;
					end else begin
						sts_valid_d = 1'b1;
						sts_check_d = 1'b1;
					end
				end
			end
			ST_LOOK: begin
				if (geo_ack) begin
					res_d = '{default: 8'h00};
					res_d[0] = RSP_PAGE_CODE;
					res_d[2] = RSP_PAGE_LEN[15:8];
					res_d[3] = RSP_PAGE_LEN[7:0];
					res_d[IDX_SUP] = {5'h00, geo_fmt};
					res_d[IDX_TGT] = {5'h00, pg_q[IDX_TGT][2:0]};
					if (geo_to_phys) begin
						{res_d[6], res_d[7], res_d[8]} = geo_cyl_in;
						res_d[9] = geo_head_in;
						{res_d[10], res_d[11], res_d[12], res_d[13]} = geo_sec_in;
					end else begin
						{res_d[6], res_d[7], res_d[8], res_d[9],
							res_d[10], res_d[11], res_d[12], res_d[13]} = geo_lba_in;
					end
					ridx_d = 4'h0;
					st_d = ST_SEND;
				end
			end
			ST_SEND: begin
				if (rsp_ready) begin
					// wrap so the answer mux never points past the page while idle
					ridx_d = (ridx_q == IDX_LAST) ? 4'h0 : ridx_q + 4'h1;
					if (ridx_q == IDX_LAST) begin
						st_d = ST_IDLE;
						sts_valid_d = 1'b1;
					end
				end
			end
		endcase
	end

	// registers only
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_q <= ST_IDLE;
			pg_q <= '{default: 8'h00};
			res_q <= '{default: 8'h00};
			idx_q <= 4'h0;
			ridx_q <= 4'h0;
			have_q <= 1'b0;
			sts_valid_q <= 1'b0;
			sts_check_q <= 1'b0;
		end else begin
			st_q <= st_d;
			pg_q <= pg_d;
			res_q <= res_d;
			idx_q <= idx_d;
			ridx_q <= ridx_d;
			have_q <= have_d;
			sts_valid_q <= sts_valid_d;
			sts_check_q <= sts_check_d;
		end
	end

	// =========================================================
	// checks
	// =========================================================
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	chk_status_after_page: assert property (
		take_w && par_last |=> sts_valid)
		else $error("page end without status");
	chk_check_on_bad: assert property (
		take_w && par_last && !good_w |=> sts_check && sts_key == KEY_ILLEGAL
		&& sts_asc == ASC_BAD_PARAM)
		else $error("bad page not answered with check");
	chk_lookup_on_receive: assert property (
		$rose(geo_req) |-> $past(rcv_req) && $past(have_q))
		else $error("lookup started without receive");
	chk_good_codes: assert property (
		good_w |-> (fmt_block(sup_w) || fmt_phys(sup_w))
		&& (fmt_block(tgt_w) || fmt_phys(tgt_w)) && sup_w != tgt_w)
		else $error("unknown or equal codes accepted");
	chk_short_tail: assert property (
		good_w && sup_w == FMT_SHORT |-> tail_zero_w)
		else $error("short block tail not zero");
	chk_long_address: assert property (
		geo_req && geo_fmt == FMT_LONG |-> geo_lba[7:0] == pg_q[13]
		&& geo_lba[63:56] == pg_q[6])
		else $error("long address bytes misplaced");
	chk_phys_fields: assert property (
		geo_req && fmt_phys(geo_fmt) |-> geo_head == pg_q[9]
		&& geo_cyl[23:16] == pg_q[6] && geo_sec[7:0] == pg_q[13])
		else $error("physical fields misplaced");
	chk_lookup_hold: assert property (
		geo_req && !geo_ack |=> geo_req && $stable(geo_lba))
		else $error("lookup dropped before answer");
	chk_answer_end: assert property (
		rsp_valid && rsp_ready && rsp_last |=> !rsp_valid && sts_valid && !sts_check)
		else $error("answer end without good status");

	cov_good_page: cover property (take_w && par_last && good_w ##1 sts_valid);
	cov_bad_page: cover property (sts_valid && sts_check);
	cov_empty_receive: cover property (rcv_req && !par_valid && !have_q && st_q == ST_IDLE
		##1 sts_check);
	cov_full_answer: cover property (geo_req && geo_ack ##[1:40] rsp_last && rsp_ready);
endmodule : dat_core
`default_nettype wire

/* File: include/dat_pkg.sv */
// constants shared by the address translation diagnostic block
package dat_pkg;
	// parameter page geometry
	localparam int PAGE_BYTES = 14;
	localparam logic [3:0] IDX_SUP = 4'h4;
	localparam logic [3:0] IDX_TGT = 4'h5;
	localparam logic [3:0] IDX_LAST = 4'hd;
	localparam logic [3:0] IDX_FULL = 4'he;
	// answer page header
	localparam logic [7:0] RSP_PAGE_CODE = 8'h40;
	localparam logic [15:0] RSP_PAGE_LEN = 16'h000a;
	// address format codes, shared by supplied and target fields
	localparam logic [2:0] FMT_SHORT = 3'h0;
	localparam logic [2:0] FMT_LONG = 3'h3;
	localparam logic [2:0] FMT_BFI = 3'h4;
	localparam logic [2:0] FMT_PSEC = 3'h5;
	// status answer
	localparam logic [3:0] KEY_NONE = 4'h0;
	localparam logic [3:0] KEY_ILLEGAL = 4'h5;
	localparam logic [7:0] ASC_NONE = 8'h00;
	localparam logic [7:0] ASC_BAD_PARAM = 8'h26;
	// control states, gray along idle, lookup, send
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_LOOK = 2'h1,
		ST_SEND = 2'h3
	} dat_state_e;
endpackage : dat_pkg

/* File: verification/dat_geo_model.sv */
// geometry lookup stand-in answering the translation block
`timescale 1ns/1ns
`default_nettype none
module dat_geo_model (
	// clock, reset and pacing
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic slow,
	// lookup request
	input wire logic geo_req,
	input wire logic geo_to_phys,
	input wire logic [63:0] geo_lba,
	input wire logic [23:0] geo_cyl,
	input wire logic [7:0] geo_head,
	input wire logic [31:0] geo_sec,
	// lookup answer
	output logic geo_ack,
	output logic [63:0] geo_lba_in,
	output logic [23:0] geo_cyl_in,
	output logic [7:0] geo_head_in,
	output logic [31:0] geo_sec_in
);
	// ========================================
	// toy mapping
	logic [3:0] cnt_q;
	logic [63:0] res;
	// results read inverted outside the ack cycle so stale capture shows up
	assign res = geo_to_phys ? geo_lba ^ 64'h0123456789abcdef :
		{geo_cyl, geo_head, geo_sec} ^ 64'hfedcba9876543210;
	assign {geo_cyl_in, geo_head_in, geo_sec_in} = geo_ack ? res : ~res;
	assign geo_lba_in = geo_ack ? res : ~res;
	// one ack pulse, at once or after a slow wait
	always_ff @(posedge sys_clk) begin
		geo_ack <= 1'b0;
		if (rst || !geo_req || geo_ack) cnt_q <= 4'h0;
		else if (cnt_q == (slow ? 4'h7 : 4'h0)) geo_ack <= 1'b1;
		else cnt_q <= cnt_q + 4'h1;
	end
endmodule : dat_geo_model
`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench for the address translation block
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import dat_pkg::*;
;
	// ========================================
	// stimulus and wiring
	logic sys_clk = 0, rst = 1, par_valid = 0, par_last = 0, rcv_req = 0;
	logic rsp_ready = 0, slow = 0;
	logic [7:0] par_data = 8'h00;
	logic sts_valid, sts_check, geo_req, geo_to_phys, geo_ack, rsp_valid, rsp_last;
	logic [3:0] sts_key;
	logic [7:0] sts_asc, geo_head, geo_head_in, rsp_data;
	logic [2:0] geo_fmt;
	logic [63:0] geo_lba, geo_lba_in;
	logic [23:0] geo_cyl, geo_cyl_in;
	logic [31:0] geo_sec, geo_sec_in;
	int n_fail = 0, n_checks = 0;
	localparam logic [63:0] KP = 64'h0123456789abcdef, KL = 64'hfedcba9876543210;
	dat_core i_dut (.sys_clk, .rst, .par_valid, .par_data, .par_last, .rcv_req,
		.sts_valid, .sts_check, .sts_key, .sts_asc, .geo_req, .geo_to_phys, .geo_fmt,
		.geo_lba, .geo_cyl, .geo_head, .geo_sec, .geo_ack, .geo_lba_in, .geo_cyl_in,
		.geo_head_in, .geo_sec_in, .rsp_valid, .rsp_data, .rsp_last, .rsp_ready);
	dat_geo_model i_geo (.sys_clk, .rst, .slow, .geo_req, .geo_to_phys, .geo_lba,
		.geo_cyl, .geo_head, .geo_sec, .geo_ack, .geo_lba_in, .geo_cyl_in,
		.geo_head_in, .geo_sec_in);
	initial forever #2 sys_clk = ~sys_clk;
	task automatic chk(string n, logic [63:0] e, logic [63:0] s);
		n_checks++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// bounded wait for the status pulse, then judge it
	task automatic wait_sts(logic ck);
		int i;
		i = 0;
		// judged one step after the edge, where the registered pulse has settled
		while (sts_valid !== 1'b1 && i < 60) begin
			@(posedge sys_clk);
			#1;
			i++;
		end
		chk("sts_valid", 1'b1, sts_valid);
		chk("sts_check", ck, sts_check);
		chk("sts_key", ck ? KEY_ILLEGAL : KEY_NONE, sts_key);
		chk("sts_asc", ck ? ASC_BAD_PARAM : ASC_NONE, sts_asc);
		@(posedge sys_clk);
		#1;
	endtask : wait_sts
	task automatic send_page(logic [2:0] s, logic [2:0] t, logic [63:0] a, int n);
		for (int b = 0; b < n; b++) begin
			par_valid = 1;
			par_last = (b == n - 1);
			par_data = b == 4 ? 8'(s) : b == 5 ? 8'(t) :
				(b > 5 && b < 14) ? a[8*(13-b) +: 8] : 8'h00;
			@(posedge sys_clk);
			#1;
		end
		par_valid = 0;
		par_last = 0;
	endtask : send_page
	// receive with optional host stalls; good status follows the last byte
	task automatic rcv(logic [2:0] s, logic [2:0] t, logic [63:0] r, logic stall);
		logic [7:0] ex;
		int i, k;
		i = 0;
		k = 0;
		rcv_req = 1;
		@(posedge sys_clk);
		#1;
		rcv_req = 0;
		// look just before the edge, where the byte and its qualifiers are settled
		while (i < 14 && k < 200) begin
			k++;
			rsp_ready = !stall || k[0];
			#2;
			if (geo_req === 1'b1) begin
				chk("geo_fmt", s, geo_fmt);
				chk("geo_to_phys", s == FMT_SHORT || s == FMT_LONG, geo_to_phys);
			end
			if (rsp_valid === 1'b1 && rsp_ready) begin
				ex = i == 0 ? 8'h40 : i == 3 ? 8'h0a : i == 4 ? 8'(s) : i == 5 ? 8'(t) : 8'h00;
				chk("rsp_data", i > 5 ? r[8*(13-i) +: 8] : ex, rsp_data);
				chk("rsp_last", i == 13, rsp_last);
				i++;
			end
			@(posedge sys_clk);
			#1;
		end
		rsp_ready = 0;
		chk("rsp_count", 14, i);
		wait_sts(0);
	endtask : rcv
	task automatic t_good();
		send_page(FMT_SHORT, FMT_PSEC, 64'h89abcdef_00000000, 14);
		wait_sts(0);
		rcv(FMT_SHORT, FMT_PSEC, {32'h0, 32'h89abcdef} ^ KP, 1);
		slow = 1;
		send_page(FMT_LONG, FMT_BFI, 64'h0011223344556677, 14);
		wait_sts(0);
		rcv(FMT_LONG, FMT_BFI, 64'h0011223344556677 ^ KP, 0);
		send_page(FMT_PSEC, FMT_LONG, 64'h123456_78_9abcdef0, 14);
		wait_sts(0);
		rcv(FMT_PSEC, FMT_LONG, 64'h123456789abcdef0 ^ KL, 1);
		slow = 0;
		send_page(FMT_BFI, FMT_LONG, 64'h0000a1_02_00000c00, 14);
		wait_sts(0);
		rcv(FMT_BFI, FMT_LONG, 64'h0000a10200000c00 ^ KL, 0);
		// the page stays pending, so a second receive answers the same way
		rcv(FMT_BFI, FMT_LONG, 64'h0000a10200000c00 ^ KL, 1);
	endtask : t_good
	// illegal format pairs, nonzero short tail, truncated page
	task automatic t_bad();
		logic [5:0] p [8] = '{6'h03, 6'h1b, 6'h25, 6'h28, 6'h0c, 6'h07, 6'h00, 6'h33};
		for (int j = 0; j < 8; j++) begin
			send_page(p[j][5:3], p[j][2:0], 64'h0, 14);
			wait_sts(1);
		end
		send_page(FMT_SHORT, FMT_PSEC, 64'h1, 14);
		wait_sts(1);
		send_page(FMT_LONG, FMT_BFI, 64'h0, 13);
		wait_sts(1);
		// an overlong page is refused as well
		send_page(FMT_LONG, FMT_BFI, 64'h0, 15);
		wait_sts(1);
	endtask : t_bad
	task automatic give_verdict();
		if (n_fail == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : give_verdict
	initial begin
		#40000;
		n_fail++;
		give_verdict();
	end
	// ========================================
	// main sequence
	initial begin
		repeat (12) @(posedge sys_clk);
		#1;
		rst = 0;
		// first request only after the edge that has seen reset low
		@(posedge sys_clk);
		#1;
		rcv_req = 1;
		@(posedge sys_clk);
		#1;
		rcv_req = 0;
		wait_sts(1);
		t_good();
		t_bad();
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
